// ### pkg/nfau_consts.svh
// Purpose: Offsets, fields, reset values and timing counts of the flash access unit
// Assumes: 8-bit host register port, 50 MHz clock
// Notes:   Functional notes follow
//
// Functional notes
// - 8192-byte array, all readable by host
// - Top six bytes hold station address, MSB first
// - Address page is erasable like any page
// - Program clears bits only; one byte each
// - Erase sets whole 512-byte page to ones
// - Self-timed ops; registers stay usable meanwhile
// - Completion interrupt after each program or erase
// - Unkeyed attempt blocks program/erase until reset
// - Reads never gated by lock state
// - Erase trigger 0x01 erases addressed page
// - Data port write programs addressed byte
// - Data port read returns addressed byte promptly
// - Auto-read returns byte then increments address
// - Busy bit set during program or erase
// - Status shows last completed op type
// - Upper four status bits read zero
// - Key register is write-only
// - Address is high byte concatenated low byte
// - Only erase bit 0 starts erase
// - Low address byte holds eight LSBs
`ifndef NFAU_CONSTS_SVH
`define NFAU_CONSTS_SVH
`define NFAU_OFS_AUTORD    8'h05
`define NFAU_OFS_DATA      8'h06
`define NFAU_OFS_KEY       8'h67
`define NFAU_OFS_ADDRL     8'h68
`define NFAU_OFS_ADDRH     8'h69
`define NFAU_OFS_ERASE     8'h6A
`define NFAU_OFS_STATUS    8'h7B
`define NFAU_KEY_FIRST     8'hA5
`define NFAU_KEY_SECOND    8'hF1
`define NFAU_BIT_BUSY      3
`define NFAU_BIT_LASTPROG  1
`define NFAU_BIT_LASTERASE 0
`define NFAU_BIT_ERASE_GO  0
`define NFAU_ARRAY_BYTES   8192
`define NFAU_PAGE_BYTES    512
`define NFAU_SADDR_BASE    13'h1FFA
`define NFAU_RESET_BYTE    8'h00
`define NFAU_ERASED_BYTE   8'hFF
`define NFAU_CLK_MHZ       50
`define NFAU_PROG_US       40
`define NFAU_ERASE_MS      11
`define NFAU_PROG_CYC      (`NFAU_PROG_US * `NFAU_CLK_MHZ)
`define NFAU_ERASE_CYC     (`NFAU_ERASE_MS * 1000 * `NFAU_CLK_MHZ)
`endif

// ### pkg/nfau_pkg.sv
// Purpose: Types of the flash access unit
// Assumes: nothing
// Notes:   Sequencer states are one-hot
package nfau_pkg;
  typedef enum logic [2:0] {
    NFAU_IDLE  = 3'b001,
    NFAU_PROG  = 3'b010,
    NFAU_ERASE = 3'b100
  } nfau_state_type;
  typedef enum logic [2:0] {
    NFAU_LOCKED  = 3'b001,
    NFAU_HALFKEY = 3'b010,
    NFAU_OPEN    = 3'b100
  } nfau_lock_type;
endpackage

// ### rtl/nfau_flash_access.sv
// Purpose: Byte-register access, lock and key, and self-timed program/erase of 8 kB array
// Assumes: Host strobes are synchronous one-cycle pulses on clk
// Notes:   Read data is combinational from the array, valid in the strobe cycle
`timescale 1ns/10ps
`include "nfau_consts.svh"
module nfau_flash_access
  import nfau_pkg::*;
#(
  parameter int  ERASE_CYC = `NFAU_ERASE_CYC,
  parameter int  PROG_CYC  = `NFAU_PROG_CYC,
  parameter logic [47:0] STATION_ADDR = 48'h02_00_00_00_00_01 // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Host register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_hit,
  // Events
  output logic            op_done_irq,
  output logic            locked_out
);

  localparam int AW = 13;
  localparam int PW = 9;

  // ==========================================================
  // Array
  logic [7:0]  mem [`NFAU_ARRAY_BYTES];
  logic [7:0]  addr_high_reg;
  logic [7:0]  addr_low_reg;
  logic [15:0] full_addr;
  logic [7:0]  rd_byte;

  assign full_addr = {addr_high_reg, addr_low_reg};
  assign rd_byte   = mem[full_addr[AW-1:0]];

  // ==========================================================
  // Decode
  logic wr_key, wr_addrl, wr_addrh, wr_data, wr_erase, rd_auto;
  assign wr_key   = ce && reg_wr && reg_addr == `NFAU_OFS_KEY;
  assign wr_addrl = ce && reg_wr && reg_addr == `NFAU_OFS_ADDRL;
  assign wr_addrh = ce && reg_wr && reg_addr == `NFAU_OFS_ADDRH;
  assign wr_data  = ce && reg_wr && reg_addr == `NFAU_OFS_DATA;
  assign wr_erase = ce && reg_wr && reg_addr == `NFAU_OFS_ERASE
                    && reg_wdata[`NFAU_BIT_ERASE_GO];
  assign rd_auto  = ce && reg_rd && reg_addr == `NFAU_OFS_AUTORD;

  // ==========================================================
  // Sequencer state
  nfau_state_type state_reg;
  nfau_lock_type  lock_reg;
  logic           blocked_reg;
  logic [31:0]    timer_reg;
  logic [15:0]    op_addr_reg;
  logic [7:0]     op_data_reg;
  logic           last_prog_reg;
  logic           last_erase_reg;
  logic           busy;
  logic           attempt;
  logic           granted;
  logic           finish;
  logic [PW-1:0]  erase_idx_reg;

  assign busy    = state_reg != NFAU_IDLE;
  assign attempt = (wr_data || wr_erase) && !busy;
  assign granted = attempt && lock_reg == NFAU_OPEN && !blocked_reg;
  assign finish  = ce && busy && timer_reg == 32'd0;

  // Lock and key
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg <= NFAU_LOCKED;
    end else if (attempt) begin
      lock_reg <= NFAU_LOCKED;
    end else if (wr_key) begin
      unique case (lock_reg)
        NFAU_LOCKED:  lock_reg <= (reg_wdata == `NFAU_KEY_FIRST) ? NFAU_HALFKEY : NFAU_LOCKED;
        NFAU_HALFKEY: lock_reg <= (reg_wdata == `NFAU_KEY_SECOND) ? NFAU_OPEN : NFAU_LOCKED;
        NFAU_OPEN:    lock_reg <= NFAU_LOCKED;
        default:      lock_reg <= NFAU_LOCKED;
      endcase
    end
  end

  // Permanent block after an unkeyed attempt
  always_ff @(posedge clk) begin
    if (rst) begin
      blocked_reg <= 1'b0;
    end else if (attempt && lock_reg != NFAU_OPEN) begin
      blocked_reg <= 1'b1;
    end
  end
  assign locked_out = blocked_reg;

  // Operation timing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= NFAU_IDLE;
      timer_reg     <= 32'd0;
      op_addr_reg   <= 16'h0000;
      op_data_reg   <= 8'h00;
      erase_idx_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        NFAU_IDLE: begin
          if (granted) begin
            op_addr_reg   <= full_addr;
            op_data_reg   <= reg_wdata;
            erase_idx_reg <= '0;
            if (wr_data) begin
              state_reg <= NFAU_PROG;
              timer_reg <= 32'(PROG_CYC - 1);
            end else begin
              state_reg <= NFAU_ERASE;
              timer_reg <= 32'(ERASE_CYC - 1);
            end
          end
        end
        NFAU_PROG, NFAU_ERASE: begin
          if (state_reg == NFAU_ERASE && erase_idx_reg != '1) begin
            erase_idx_reg <= erase_idx_reg + 1'b1;
          end
          if (timer_reg == 32'd0) begin
            state_reg <= NFAU_IDLE;
          end else begin
            timer_reg <= timer_reg - 32'd1;
          end
        end
        default: state_reg <= NFAU_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Array updates: program at the end, erase one byte per cycle
  logic [AW-1:0] erase_target;
  assign erase_target = {op_addr_reg[AW-1:PW], erase_idx_reg};

  initial begin
    for (int i = 0; i < `NFAU_ARRAY_BYTES; i++) begin
      mem[i] = `NFAU_ERASED_BYTE;
    end
    for (int j = 0; j < 6; j++) begin
      mem[`NFAU_SADDR_BASE + j] = STATION_ADDR[47 - 8*j -: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (ce && state_reg == NFAU_ERASE) begin
      mem[erase_target] <= `NFAU_ERASED_BYTE;
    end else if (finish && state_reg == NFAU_PROG) begin
      mem[op_addr_reg[AW-1:0]] <= mem[op_addr_reg[AW-1:0]] & op_data_reg;
    end
  end

  // ==========================================================
  // Address pair with auto increment
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_low_reg  <= `NFAU_RESET_BYTE;
      addr_high_reg <= `NFAU_RESET_BYTE;
    end else if (rd_auto) begin
      {addr_high_reg, addr_low_reg} <= full_addr + 16'd1;
    end else begin
      if (wr_addrl) begin
        addr_low_reg <= reg_wdata;
      end
      if (wr_addrh) begin
        addr_high_reg <= reg_wdata;
      end
    end
  end

  // Completion status and interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      last_prog_reg  <= 1'b0;
      last_erase_reg <= 1'b0;
      op_done_irq    <= 1'b0;
    end else if (ce) begin
      // Gated by ce so a frozen block also holds its completion pulse
      op_done_irq <= finish;
      if (finish) begin
        last_prog_reg  <= state_reg == NFAU_PROG;
        last_erase_reg <= state_reg == NFAU_ERASE;
      end
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    reg_rdata = 8'h00;
    reg_hit   = 1'b1;
    unique case (reg_addr)
      `NFAU_OFS_AUTORD, `NFAU_OFS_DATA: reg_rdata = rd_byte;
      `NFAU_OFS_ADDRL:  reg_rdata = addr_low_reg;
      `NFAU_OFS_ADDRH:  reg_rdata = addr_high_reg;
      `NFAU_OFS_ERASE:  reg_rdata = 8'h00;
      `NFAU_OFS_KEY:    reg_rdata = 8'h00;
      `NFAU_OFS_STATUS: reg_rdata = {4'h0, busy, 1'b0, last_prog_reg, last_erase_reg};
      default:          reg_hit   = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks: operation start and lock
  logic [AW-1:0] prog_ix;
  assign prog_ix = op_addr_reg[AW-1:0];

  a_busy_after_grant: assert property (@(posedge clk) disable iff (rst)
    granted && ce |=> busy)
    else $error("grant did not start operation");

  a_relock_after_op: assert property (@(posedge clk) disable iff (rst)
    attempt |=> lock_reg == NFAU_LOCKED)
    else $error("lock not restored");

  a_key_first: assert property (@(posedge clk) disable iff (rst)
    wr_key && lock_reg == NFAU_LOCKED && reg_wdata == `NFAU_KEY_FIRST |=> lock_reg == NFAU_HALFKEY)
    else $error("first key not taken");

  a_key_second: assert property (@(posedge clk) disable iff (rst)
    wr_key && lock_reg == NFAU_HALFKEY && reg_wdata == `NFAU_KEY_SECOND |=> lock_reg == NFAU_OPEN)
    else $error("second key not taken");

  a_open_needs_key: assert property (@(posedge clk) disable iff (rst)
    lock_reg == NFAU_OPEN && $past(lock_reg) != NFAU_OPEN |-> $past(wr_key))
    else $error("opened without key");

  a_block_sticks: assert property (@(posedge clk) disable iff (rst)
    attempt && lock_reg != NFAU_OPEN |=> blocked_reg && !busy)
    else $error("block missing");

  a_block_holds: assert property (@(posedge clk) disable iff (rst)
    blocked_reg |=> blocked_reg)
    else $error("block released");

  a_no_grant_blocked: assert property (@(posedge clk) disable iff (rst)
    blocked_reg |-> !granted)
    else $error("grant while blocked");

  a_no_second_op: assert property (@(posedge clk) disable iff (rst)
    busy && !finish |=> $stable(op_addr_reg))
    else $error("second op while busy");

  a_erase_bit_only: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && reg_addr == `NFAU_OFS_ERASE && !reg_wdata[0] && !busy |=> !busy)
    else $error("erase without go bit");

  // ==========================================================
  // Checks: timing and completion
  a_prog_timer: assert property (@(posedge clk) disable iff (rst)
    state_reg == NFAU_PROG |-> timer_reg < 32'(PROG_CYC))
    else $error("program timer out of range");

  a_erase_timer: assert property (@(posedge clk) disable iff (rst)
    state_reg == NFAU_ERASE |-> timer_reg < 32'(ERASE_CYC))
    else $error("erase timer out of range");

  a_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(state_reg) && $stable(timer_reg) && $stable(lock_reg) && $stable(op_done_irq))
    else $error("state moved while frozen");

  a_irq_on_finish: assert property (@(posedge clk) disable iff (rst)
    finish |=> op_done_irq)
    else $error("no completion pulse");

  a_irq_one_cycle: assert property (@(posedge clk) disable iff (rst)
    op_done_irq |=> !op_done_irq)
    else $error("completion pulse too long");

  a_last_type: assert property (@(posedge clk) disable iff (rst)
    finish && state_reg == NFAU_ERASE |=> last_erase_reg && !last_prog_reg)
    else $error("erase type lost");

  a_last_prog_type: assert property (@(posedge clk) disable iff (rst)
    finish && state_reg == NFAU_PROG |=> last_prog_reg && !last_erase_reg)
    else $error("program type lost");

  // ==========================================================
  // Checks: array contents
  a_prog_clears: assert property (@(posedge clk) disable iff (rst)
    finish && state_reg == NFAU_PROG |=> (mem[$past(prog_ix)] & ~$past(op_data_reg)) == 8'h00)
    else $error("programmed bit left at one");

  a_prog_no_set: assert property (@(posedge clk) disable iff (rst)
    finish && state_reg == NFAU_PROG |=> (mem[$past(prog_ix)] & ~$past(mem[prog_ix])) == 8'h00)
    else $error("program raised a bit");

  a_erase_ones: assert property (@(posedge clk) disable iff (rst)
    ce && state_reg == NFAU_ERASE |=> mem[$past(erase_target)] == `NFAU_ERASED_BYTE)
    else $error("erased byte not ones");

  // ==========================================================
  // Checks: register reads and address pair
  a_autoinc_step: assert property (@(posedge clk) disable iff (rst)
    rd_auto |=> full_addr == $past(full_addr) + 16'h0001)
    else $error("no increment");

  a_addr_hold: assert property (@(posedge clk) disable iff (rst)
    !rd_auto && !wr_addrl && !wr_addrh |=> $stable(full_addr))
    else $error("address moved");

  a_addr_low_write: assert property (@(posedge clk) disable iff (rst)
    wr_addrl |=> addr_low_reg == $past(reg_wdata))
    else $error("low address not written");

  a_read_ungated: assert property (@(posedge clk) disable iff (rst)
    reg_addr == `NFAU_OFS_DATA |-> reg_rdata == mem[full_addr[AW-1:0]])
    else $error("data read wrong");

  a_key_reads_zero: assert property (@(posedge clk) disable iff (rst)
    reg_addr == `NFAU_OFS_KEY |-> reg_rdata == 8'h00)
    else $error("key register readable");

  a_status_upper: assert property (@(posedge clk) disable iff (rst)
    reg_addr == `NFAU_OFS_STATUS |-> reg_rdata[7:4] == 4'h0)
    else $error("status upper");

  a_status_busy: assert property (@(posedge clk) disable iff (rst)
    reg_addr == `NFAU_OFS_STATUS |-> reg_rdata[`NFAU_BIT_BUSY] == busy)
    else $error("busy bit");

endmodule

// ### tb/nfau_host_model.sv
// Purpose: Host processor model on the register port
// Assumes: One-cycle strobes launched 1 ns after clk rises
// Notes:   Released address and data lines show the inverse of the last value; strobes return to 0
`timescale 1ns/10ps
module nfau_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // ==========================================
  // One access; data sampled mid strobe cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic h);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = ~w;
    @(negedge clk);
    q = reg_rdata;
    h = reg_hit;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // Both key codes in order; callers erase first unless only clearing bits
  task automatic unlock();
    logic [7:0] q;
    logic       h;
    acc(1'b1, 8'h67, 8'hA5, q, h);
    acc(1'b1, 8'h67, 8'hF1, q, h);
  endtask
endmodule

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the flash access unit
// Assumes: Short program and erase counts
// Notes:   Hand tests follow the table loop
`timescale 1ns/10ps
module tb_top;
  localparam logic [47:0] SADDR = 48'h0A1B2C3D4E5F; // Arbitrary value
  typedef struct {logic [7:0] a; logic [7:0] e; logic h;} nfau_row_type;
  logic       clk;
  logic       rst;
  logic       ce;
  logic       reg_wr;
  logic       reg_rd;
  logic       reg_hit;
  logic       op_done_irq;
  logic       locked_out;
  logic       h;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] q;
  int         err_count;
  int         n_compared;
  int         cyc;
  nfau_row_type rows [6] = '{'{8'h7B, 8'h00, 1'b1}, '{8'h67, 8'h00, 1'b1},
    '{8'h6A, 8'h00, 1'b1}, '{8'h06, 8'hFF, 1'b1}, '{8'h69, 8'h00, 1'b1},
    '{8'h00, 8'h00, 1'b0}};
  nfau_flash_access #(.ERASE_CYC(600), .PROG_CYC(8), .STATION_ADDR(SADDR))
    i_nfau_flash_access (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .op_done_irq(op_done_irq), .locked_out(locked_out));
  nfau_host_model i_nfau_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  // ==========================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_nfau_host_model.acc(1'b1, a, d, q, h);
  endtask
  task automatic rd(input logic [7:0] a);
    i_nfau_host_model.acc(1'b0, a, 8'h00, q, h);
  endtask
  task automatic seta(input logic [15:0] a);
    wr(8'h68, a[7:0]);
    wr(8'h69, a[15:8]);
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (op_done_irq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, n < lim}, 8'h01, "completion pulse");
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {err_count, n_compared, cyc} = '0;
    rst = 1'b1;
    ce  = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(q, rows[i].e, "reset read");
      chk({7'h00, h}, {7'h00, rows[i].h}, "hit");
    end
    $display("test table done");
    seta(16'h1FFA);
    for (int i = 0; i < 6; i++) begin
      rd(8'h05);
      chk(q, SADDR[47-8*i -: 8], "station byte");
    end
    rd(8'h68);
    chk(q, 8'h00, "addr low");
    rd(8'h69);
    chk(q, 8'h20, "addr high");
    $display("test autoread done");
    seta(16'h0010);
    i_nfau_host_model.unlock();
    wr(8'h06, 8'h5A);
    rd(8'h7B);
    chk(q, 8'h08, "busy");
    wr(8'h06, 8'h00);
    wait_done(50);
    rd(8'h7B);
    chk(q, 8'h02, "prog status");
    rd(8'h06);
    chk(q, 8'h5A, "prog byte");
    chk({7'h00, locked_out}, 8'h00, "no lockout");
    i_nfau_host_model.unlock();
    wr(8'h06, 8'h0F);
    wait_done(50);
    rd(8'h06);
    chk(q, 8'h0A, "bits clear only");
    wr(8'h7B, 8'hF0);
    rd(8'h7B);
    chk(q, 8'h02, "upper status");
    $display("test program done");
    seta(16'h1FFA);
    i_nfau_host_model.unlock();
    wr(8'h6A, 8'h02);
    rd(8'h7B);
    chk(q, 8'h02, "bit1 no erase");
    wr(8'h6A, 8'h01);
    wait_done(700);
    rd(8'h7B);
    chk(q, 8'h01, "erase status");
    seta(16'h1E00);
    rd(8'h05);
    chk(q, 8'hFF, "page start");
    seta(16'h1FFF);
    rd(8'h05);
    chk(q, 8'hFF, "station erased");
    seta(16'h0010);
    rd(8'h06);
    chk(q, 8'h0A, "other page");
    $display("test erase done");
    wr(8'h06, 8'h00);
    chk({7'h00, locked_out}, 8'h01, "unkeyed attempt");
    i_nfau_host_model.unlock();
    wr(8'h06, 8'h00);
    rd(8'h7B);
    chk(q, 8'h01, "blocked op");
    rd(8'h06);
    chk(q, 8'h0A, "read while locked");
    $display("test lockout done");
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    chk({7'h00, locked_out}, 8'h00, "lockout cleared");
    rd(8'h7B);
    chk(q, 8'h00, "status reset");
    $display("test reset done");
    final_report();
  end
endmodule
